// ### rtl/lbsa_pkg.sv
package lbsa_pkg;

   // ==========================================================
   // Register addresses on the special-function register port
   // ==========================================================
   localparam logic [7:0] SCON_ADDR      = 8'hc8;
   localparam logic [7:0] LINCTL_ADDR    = 8'hc9;
   localparam logic [7:0] PINCFG_ADDR    = 8'hca;
   localparam logic [7:0] RELOAD_LO_ADDR = 8'hcb;
   localparam logic [7:0] RELOAD_HI_ADDR = 8'hcc;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int OVR_BIT  = 7;
   localparam int PARITY_ERROR_FLAG_BIT = 6;
   localparam int REN_BIT  = 4;
   localparam int TBX_BIT  = 3;
   localparam int RBX_BIT  = 2;
   localparam int TI_BIT   = 1;
   localparam int RI_BIT   = 0;

   localparam logic [7:0]  SCON_RESET   = 8'h00;
   localparam logic [7:0]  LINCTL_RESET = 8'h00;
   localparam logic [1:0]  RX_SOURCE_SELECT_RESET  = 2'h0;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;

   // ==========================================================
   // Measurement figures
   // ==========================================================
   localparam logic [16:0] RELOAD_SPAN       = 17'h10000;
   localparam logic [16:0] MIN_RELOAD_COUNT  = 17'h00032;
   localparam logic [15:0] MAX_RELOAD        = 16'hffce;
   localparam logic [20:0] BREAK_BITS        = 21'h00000b;
   localparam logic [2:0]  SYNC_RISE_EDGES   = 3'h5;
   localparam logic [19:0] SYNC_TIMEOUT_TICKS = 20'h186a0;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic lin_mode_enable;
      logic autobaud_enable;
      logic break_done_irq_enable;
      logic sync_detected_irq_enable;
      logic sync_timeout_irq_enable;
      logic break_done_flag;
      logic sync_detected_flag;
      logic sync_timeout_flag;
   } lbsa_lin_ctrl_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DELIM,
      ST_START,
      ST_FIRST,
      ST_MEAS
   } lbsa_sync_state_type;

endpackage

// ### rtl/lbsa_lin_autobaud.sv
`timescale 1ns/1ps
// Behaviour
// - LIN mode enables break detection on all received data; sync detection follows a break.
// - A break seen mid-stream restarts sync detection from that break.
// - A detected break sets the break done flag.
// - Valid sync sets sync detected; sync timeout sets sync timeout flag.
// - Each flag reaches the interrupt only when its own enable is set.
// - Autobaud runs when its enable is set, with or without LIN mode.
// - In LIN mode baud changes only after break, delimiter, then 0x55.
// - In LIN mode autobaud ignores ordinary frames without a break.
// - Without LIN mode the next word is measured as 0x55, no break.
// - Sync duration in prescaled ticks gives the new reload value.
// - Ticks count from first to last rising edge of the sync field.
// - Reload count is at least 50; written reload never above 65486.
// - Receive input comes from crossbar or logic unit 0, 1 or 2.
// - Character dropped on full receive FIFO sets overrun flag bit 7.
// - Parity failure of oldest FIFO byte sets parity flag bit 6.
// - Receive enable bit 4 low stops loading characters into FIFO.
module lbsa_lin_autobaud #(
   parameter logic [19:0] SYNC_TIMEOUT = lbsa_pkg::SYNC_TIMEOUT_TICKS
) (
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   input  wire logic        rx_crossbar_i,
   input  wire logic        logic_unit_zero_i,
   input  wire logic        logic_unit_one_i,
   input  wire logic        logic_unit_two_i,
   input  wire logic        presc_tick_i,
   input  wire logic        char_done_i,
   input  wire logic        fifo_full_i,
   input  wire logic        fifo_nonempty_i,
   input  wire logic        parity_enable_i,
   input  wire logic        head_parity_err_i,
   input  wire logic        extra_receive_bit_i,
   input  wire logic        tx_done_i,
   output logic             serial_rx_o,
   output logic             fifo_load_o,
   output logic [15:0]      baud_reload_o,
   output logic             irq_o
);

   // ==========================================================
   // Register file
   // ==========================================================
   logic [7:0]                  scon_q, scon_d;
   lbsa_pkg::lbsa_lin_ctrl_type lin_q, lin_d;
   logic [1:0]                  rx_source_select_q, rx_source_select_d;
   logic [15:0]                 reload_q, reload_d;
   logic [7:0]                  rdata_d;
   logic                        rx_d, load_d, irq_d;
   logic                        brk_evt, sync_evt, to_evt;
   logic [15:0]                 new_reload;

   always_comb begin
      scon_d   = scon_q;
      lin_d    = lin_q;
      rx_source_select_d  = rx_source_select_q;
      reload_d = reload_q;
      if (sfr_wr_i) begin
         unique case (sfr_addr_i)
            lbsa_pkg::SCON_ADDR: begin
               scon_d = sfr_wdata_i & 8'hda;
            end
            lbsa_pkg::LINCTL_ADDR: begin
               // Flags are cleared by writing zero; a one leaves them.
               lin_d = lbsa_pkg::lbsa_lin_ctrl_type'(
                  (sfr_wdata_i & 8'hf8) | (sfr_wdata_i & lin_q & 8'h07));
            end
            lbsa_pkg::PINCFG_ADDR: begin
               rx_source_select_d = sfr_wdata_i[1:0];
            end
            lbsa_pkg::RELOAD_LO_ADDR: begin
               reload_d[7:0] = sfr_wdata_i;
            end
            lbsa_pkg::RELOAD_HI_ADDR: begin
               reload_d[15:8] = sfr_wdata_i;
            end
            default: begin
            end
         endcase
      end
      // Hardware sets win over a clear written in the same cycle.
      if (char_done_i && scon_q[lbsa_pkg::REN_BIT] && fifo_full_i)
         scon_d[lbsa_pkg::OVR_BIT] = 1'b1;
      if (parity_enable_i && head_parity_err_i)
         scon_d[lbsa_pkg::PARITY_ERROR_FLAG_BIT] = 1'b1;
      if (tx_done_i)
         scon_d[lbsa_pkg::TI_BIT] = 1'b1;
      if (brk_evt)
         lin_d.break_done_flag = 1'b1;
      if (sync_evt)
         lin_d.sync_detected_flag = 1'b1;
      if (to_evt)
         lin_d.sync_timeout_flag = 1'b1;
      if (sync_evt && lin_q.autobaud_enable)
         reload_d = new_reload;
      unique case (rx_source_select_q)
         2'h0: rx_d = rx_crossbar_i;
         2'h1: rx_d = logic_unit_zero_i;
         2'h2: rx_d = logic_unit_one_i;
         2'h3: rx_d = logic_unit_two_i;
      endcase
      load_d = char_done_i && scon_q[lbsa_pkg::REN_BIT]
               && !fifo_full_i;
      irq_d = (lin_q.break_done_flag && lin_q.break_done_irq_enable)
           || (lin_q.sync_detected_flag && lin_q.sync_detected_irq_enable)
           || (lin_q.sync_timeout_flag
               && lin_q.sync_timeout_irq_enable);
      unique case (sfr_addr_i)
         lbsa_pkg::SCON_ADDR: begin
            rdata_d = scon_q;
            rdata_d[lbsa_pkg::RBX_BIT] = extra_receive_bit_i;
            rdata_d[lbsa_pkg::RI_BIT]  = fifo_nonempty_i;
         end
         lbsa_pkg::LINCTL_ADDR:    rdata_d = lin_q;
         lbsa_pkg::PINCFG_ADDR:    rdata_d = {6'h00, rx_source_select_q};
         lbsa_pkg::RELOAD_LO_ADDR: rdata_d = reload_q[7:0];
         lbsa_pkg::RELOAD_HI_ADDR: rdata_d = reload_q[15:8];
         default:                  rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         scon_q        <= lbsa_pkg::SCON_RESET;
         lin_q         <= lbsa_pkg::LINCTL_RESET;
         rx_source_select_q       <= lbsa_pkg::RX_SOURCE_SELECT_RESET;
         reload_q      <= lbsa_pkg::RELOAD_RESET;
         sfr_rdata_o   <= 8'h00;
         serial_rx_o   <= 1'b1;
         fifo_load_o   <= 1'b0;
         irq_o         <= 1'b0;
      end else begin
         scon_q        <= scon_d;
         lin_q         <= lin_d;
         rx_source_select_q       <= rx_source_select_d;
         reload_q      <= reload_d;
         sfr_rdata_o   <= rdata_d;
         serial_rx_o   <= rx_d;
         fifo_load_o   <= load_d;
         irq_o         <= irq_d;
      end
   end

   assign baud_reload_o = reload_q;

   // ==========================================================
   // Break and sync detector
   // ==========================================================
   lbsa_pkg::lbsa_sync_state_type st_q, st_d;
   logic        prev_q, prev_d;
   logic [20:0] low_q, low_d, meas_q, meas_d, brk_thr;
   logic [19:0] to_q, to_d;
   logic [2:0]  edge_q, edge_d;
   logic [17:0] bit_ticks;
   logic [16:0] rc;
   logic        rise, fall;

   always_comb begin
      st_d   = st_q;
      low_d  = low_q;
      meas_d = meas_q;
      to_d   = to_q;
      edge_d = edge_q;
      prev_d = serial_rx_o;
      rise   = serial_rx_o && !prev_q;
      fall   = !serial_rx_o && prev_q;
      brk_evt  = 1'b0;
      sync_evt = 1'b0;
      to_evt   = 1'b0;
      // A break is eleven bit times low; one bit is two reload overflows.
      bit_ticks = 18'((lbsa_pkg::RELOAD_SPAN - {1'b0, reload_q}) << 1);
      brk_thr   = 21'(21'(bit_ticks) * lbsa_pkg::BREAK_BITS);
      // The tick of the closing rising edge belongs to the sync field too.
      if (presc_tick_i && meas_q != 21'h1fffff)
         meas_d = meas_q + 21'h000001;
      rc = meas_d[20:4];
      if (rc < lbsa_pkg::MIN_RELOAD_COUNT)
         rc = lbsa_pkg::MIN_RELOAD_COUNT;
      new_reload = 16'(lbsa_pkg::RELOAD_SPAN - rc);
      if (serial_rx_o)
         low_d = 21'h000000;
      else if (presc_tick_i && low_q < brk_thr)
         low_d = low_q + 21'h000001;
      if (presc_tick_i && st_q != lbsa_pkg::ST_IDLE)
         to_d = to_q + 20'h00001;
      unique case (st_q)
         lbsa_pkg::ST_IDLE: begin
            if (lin_q.autobaud_enable && !lin_q.lin_mode_enable)
               st_d = lbsa_pkg::ST_START;
         end
         lbsa_pkg::ST_DELIM: if (serial_rx_o) st_d = lbsa_pkg::ST_START;
         lbsa_pkg::ST_START: if (fall) st_d = lbsa_pkg::ST_FIRST;
         lbsa_pkg::ST_FIRST: begin
            if (rise) begin
               st_d   = lbsa_pkg::ST_MEAS;
               meas_d = 21'h000000;
               edge_d = 3'h1;
            end
         end
         lbsa_pkg::ST_MEAS: begin
            if (rise) begin
               edge_d = edge_q + 3'h1;
               if (edge_d == lbsa_pkg::SYNC_RISE_EDGES) begin
                  sync_evt = 1'b1;
                  st_d     = lbsa_pkg::ST_IDLE;
               end
            end
         end
      endcase
      if (st_q == lbsa_pkg::ST_IDLE)
         to_d = 20'h00000;
      // The timeout only guards a sync that follows a break.
      if (lin_q.lin_mode_enable && st_q != lbsa_pkg::ST_IDLE
          && !sync_evt && presc_tick_i && to_q == SYNC_TIMEOUT - 20'h1) begin
         to_evt = 1'b1;
         st_d   = lbsa_pkg::ST_IDLE;
      end
      // A break overrides any state, so one can cut into a data stream.
      if (lin_q.lin_mode_enable && !serial_rx_o && presc_tick_i
          && low_q == brk_thr - 21'h000001) begin
         brk_evt = 1'b1;
         st_d    = lbsa_pkg::ST_DELIM;
         to_d    = 20'h00000;
         to_evt  = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q   <= lbsa_pkg::ST_IDLE;
         prev_q <= 1'b1;
         low_q  <= 21'h000000;
         meas_q <= 21'h000000;
         to_q   <= 20'h00000;
         edge_q <= 3'h0;
      end else begin
         st_q   <= st_d;
         prev_q <= prev_d;
         low_q  <= low_d;
         meas_q <= meas_d;
         to_q   <= to_d;
         edge_q <= edge_d;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_load;
      char_done_i && scon_q[lbsa_pkg::REN_BIT] && !fifo_full_i;
   endsequence
   sequence s_baud_write;
      sync_evt && lin_q.autobaud_enable;
   endsequence

   chk_break_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
      brk_evt |=> lin_q.break_done_flag)
      else $error("Break did not set the break done flag.");
   chk_sync_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
      sync_evt |=> lin_q.sync_detected_flag && st_q == lbsa_pkg::ST_IDLE)
      else $error("Sync did not set the sync detected flag.");
   chk_timeout_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
      to_evt |=> lin_q.sync_timeout_flag && st_q == lbsa_pkg::ST_IDLE)
      else $error("Timeout did not set the sync timeout flag.");
   chk_irq_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
      !(lin_q.break_done_flag && lin_q.break_done_irq_enable)
      && !(lin_q.sync_detected_flag && lin_q.sync_detected_irq_enable)
      && !(lin_q.sync_timeout_flag && lin_q.sync_timeout_irq_enable)
      |=> !irq_o)
      else $error("Interrupt raised without an enabled flag.");
   chk_reload_write: assert property (@(posedge mclk_i) disable iff (reset_i)
      s_baud_write |=> reload_q == $past(new_reload)
                       && reload_q <= lbsa_pkg::MAX_RELOAD)
      else $error("Autobaud reload value wrong or out of range.");
   chk_lin_no_break: assert property (@(posedge mclk_i) disable iff (reset_i)
      lin_q.lin_mode_enable && st_q == lbsa_pkg::ST_IDLE && !brk_evt
      |=> st_q == lbsa_pkg::ST_IDLE)
      else $error("LIN sync search started without a break.");
   chk_nonlin_arm: assert property (@(posedge mclk_i) disable iff (reset_i)
      !lin_q.lin_mode_enable && lin_q.autobaud_enable
      && st_q == lbsa_pkg::ST_IDLE |=> st_q == lbsa_pkg::ST_START)
      else $error("Autobaud did not arm without LIN mode.");
   chk_fifo_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      s_load ##1 1'b1 |-> fifo_load_o)
      else $error("Enabled character not loaded.");
   chk_overrun: assert property (@(posedge mclk_i) disable iff (reset_i)
      char_done_i && scon_q[lbsa_pkg::REN_BIT] && fifo_full_i
      |=> scon_q[lbsa_pkg::OVR_BIT] && !fifo_load_o)
      else $error("Overrun not flagged.");
   chk_ren_off: assert property (@(posedge mclk_i) disable iff (reset_i)
      !scon_q[lbsa_pkg::REN_BIT] |=> !fifo_load_o)
      else $error("Character loaded while reception disabled.");
   chk_parity: assert property (@(posedge mclk_i) disable iff (reset_i)
      parity_enable_i && head_parity_err_i |=> scon_q[lbsa_pkg::PARITY_ERROR_FLAG_BIT])
      else $error("Parity error not flagged.");
   chk_rx_source: assert property (@(posedge mclk_i) disable iff (reset_i)
      rx_source_select_q == 2'h1 |=> serial_rx_o == $past(logic_unit_zero_i))
      else $error("Receive source select not honoured.");

endmodule

// ### verification/lbsa_lin_master.sv
`timescale 1ns/1ps
module lbsa_lin_master (
   input  wire logic mclk_i,
   output logic      rx_o
);
   // ==========================================================
   // Frame driver
   // ==========================================================
   // The line is pulled up, so it rests high between frames.
   initial rx_o = 1'b1;

   task automatic drive(input logic v, input int n);
      @(negedge mclk_i);
      rx_o = v;
      repeat (n - 1) @(negedge mclk_i);
   endtask

   // Bits of 200 ticks (400 cycles) or more keep the measured rate within 1%.
   task automatic send(input logic brk, input logic frm,
                       input logic [7:0] b, input int bt);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      if (brk) begin
         drive(1'b0, 13 * bt);
         drive(1'b1, bt);
      end
      if (frm) begin
         for (int i = 0; i < 10; i++) begin
            drive(f[i], bt);
         end
      end
   endtask
endmodule

// ### verification/lbsa_lin_autobaud_bench.sv
`timescale 1ns/1ps
module lbsa_lin_autobaud_bench;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        mclk_i;
   logic        reset_i;
   logic [7:0]  addr;
   logic        wr;
   logic [7:0]  wd;
   logic [7:0]  rdata;
   logic        xb;
   logic [2:0]  unit;
   logic        cd;
   logic        full;
   logic        ne;
   logic        pe;
   logic        parity_error_flag;
   logic        extra_receive_bit;
   logic        rx_line;
   logic        srx;
   logic        load;
   logic [15:0] reload;
   logic        irq;
   logic        tick;
   logic        rdm;
   logic [7:0]  d;
   logic [7:0]  rd_q[$];
   int          loads;
   int          n_mismatch;
   int          compares;
   int          seed;

   lbsa_lin_master lin (
      .mclk_i (mclk_i),
      .rx_o   (rx_line)
   );

   lbsa_lin_autobaud #(
      .SYNC_TIMEOUT (20'h01f40)
   ) dut (
      .mclk_i              (mclk_i),
      .reset_i             (reset_i),
      .sfr_addr_i          (addr),
      .sfr_wr_i            (wr),
      .sfr_wdata_i         (wd),
      .sfr_rdata_o         (rdata),
      .rx_crossbar_i       (rx_line & xb),
      .logic_unit_zero_i   (unit[0]),
      .logic_unit_one_i    (unit[1]),
      .logic_unit_two_i    (unit[2]),
      .presc_tick_i        (tick),
      .char_done_i         (cd),
      .fifo_full_i         (full),
      .fifo_nonempty_i     (ne),
      .parity_enable_i     (pe),
      .head_parity_err_i   (parity_error_flag),
      .extra_receive_bit_i (extra_receive_bit),
      .tx_done_i           (1'b0),
      .serial_rx_o         (srx),
      .fifo_load_o         (load),
      .baud_reload_o       (reload),
      .irq_o               (irq)
   );

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk_i);
      addr = a;
      wd = v;
      wr = 1'b1;
      @(negedge mclk_i);
      wr = 1'b0;
   endtask

   // Read data lags the address by one edge; the mark lands after it.
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk_i);
      addr = a;
      rd_q.push_back(e);
      repeat (2) @(negedge mclk_i);
      rdm = 1'b1;
      @(negedge mclk_i);
      rdm = 1'b0;
   endtask

   task automatic pulse_cd();
      @(negedge mclk_i);
      cd = 1'b1;
      @(negedge mclk_i);
      cd = 1'b0;
   endtask

   // ==========================================================
   // Clock, watchdog and result watcher
   // ==========================================================
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   initial begin
      #900000;
      n_mismatch++;
      close_out();
   end

   always @(posedge mclk_i) begin
      if (rdm === 1'b1) begin
         chk({8'h00, rdata}, {8'h00, rd_q.pop_front()});
      end
   end

   // Load pulses are counted mid-cycle, away from the edge that makes them.
   always @(negedge mclk_i) begin
      if (load === 1'b1) begin
         loads++;
      end
   end

   // Ticks come at half the clock rate, so cycles and ticks differ.
   always @(negedge mclk_i) begin
      tick <= ~tick;
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      {reset_i, xb, unit} = 5'h1f;
      {addr, wd, wr, cd, full, ne, pe, parity_error_flag, extra_receive_bit, rdm, tick} = '0;
      loads = 0;
      n_mismatch = 0;
      compares = 0;
      seed = 9;
      repeat (12) @(negedge mclk_i);
      reset_i = 1'b0;
      for (int i = 0; i < 6; i++) begin
         rreg(8'hc8 + 8'(i), 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         extra_receive_bit = 1'($random(seed));
         ne = 1'($random(seed));
         wreg(8'hc8, d);
         rreg(8'hc8, (d & 8'hda) | {5'h00, extra_receive_bit, 1'b0, ne});
      end
      {extra_receive_bit, ne} = 2'h0;
      wreg(8'hc8, 8'h00);
      full = 1'b1;
      pulse_cd();
      rreg(8'hc8, 8'h00);
      full = 1'b0;
      wreg(8'hc8, 8'h10);
      pulse_cd();
      pulse_cd();
      full = 1'b1;
      pulse_cd();
      full = 1'b0;
      rreg(8'hc8, 8'h90);
      chk(16'(loads), 16'h0002);
      wreg(8'hc8, 8'h10);
      {pe, parity_error_flag} = 2'h3;
      @(negedge mclk_i);
      {pe, parity_error_flag} = 2'h0;
      rreg(8'hc8, 8'h50);
      for (int s = 0; s < 4; s++) begin
         wreg(8'hca, 8'(s));
         xb = (s != 0);
         unit = ~3'((4'h1 << s) >> 1);
         repeat (3) @(negedge mclk_i);
         chk({15'h0, srx}, 16'h0000);
      end
      {xb, unit} = 4'hf;
      wreg(8'hca, 8'h00);
      wreg(8'hcb, 8'hf6);
      wreg(8'hcc, 8'hff);
      wreg(8'hc9, 8'hf8);
      lin.send(1'b0, 1'b1, 8'h55, 400);
      rreg(8'hcb, 8'hf6);
      lin.send(1'b1, 1'b1, 8'h55, 400);
      repeat (4) @(negedge mclk_i);
      rreg(8'hc9, 8'hfe);
      chk({15'h0, irq}, 16'h0001);
      rreg(8'hcb, 8'h9c);
      // Interrupt enables and flags are cleared by this write, so irq must fall and stay low.
      wreg(8'hc9, 8'hc0);
      lin.send(1'b1, 1'b0, 8'h00, 400);
      repeat (16000) @(negedge mclk_i);
      rreg(8'hc9, 8'hc5);
      chk({15'h0, irq}, 16'h0000);
      wreg(8'hc9, 8'h40);
      lin.send(1'b0, 1'b1, 8'h55, 40);
      repeat (4) @(negedge mclk_i);
      rreg(8'hc9, 8'h42);
      wreg(8'hc9, 8'h00);
      rreg(8'hcb, 8'hce);
      rreg(8'hcc, 8'hff);
      close_out();
   end
endmodule
